/* power_clock_pkg.sv */
// constants, field layouts and state types of the power clock generator
// assumes a 50 MHz system clock and a plain one-cycle register port
package power_clock_pkg;

  // clock rates and derived dividers
  localparam int SYS_HZ = 50_000_000;
  localparam int SLOW_HZ = 32768;
  localparam int SLOW_DIV = SYS_HZ / SLOW_HZ; // sys cycles per slow tick
  localparam int OSC_TICK_DIV = 8; // oscillator counter step, in cycles
  localparam int BACKUP_STRETCH = 32768; // slow cycles of backup reset
  localparam int SWITCH_TICKS = 2; // ticks of each clock in a switch
  localparam int MAIN_DIV_DEFAULT = 4; // modelled crystal rate divider

  // register offsets
  localparam logic [7:0] SYS_CLK_ENABLE_OFS = 8'h00;
  localparam logic [7:0] SYS_CLK_DISABLE_OFS = 8'h04;
  localparam logic [7:0] SYS_CLK_STATUS_OFS = 8'h08;
  localparam logic [7:0] CLOCK_GEN_MODE_OFS = 8'h20;
  localparam logic [7:0] POWER_CTRL_OFS = 8'h28;
  localparam logic [7:0] POWER_MODE_OFS = 8'h2c;
  localparam logic [7:0] POWER_STATUS_OFS = 8'h30;

  // reset values
  localparam logic [31:0] CGMR_RESET = 32'h0000_0000;
  localparam logic [1:0] POWER_MODE_RESET = 2'h1;
  localparam logic [2:0] PRESCALE_MAX = 3'h6;

  // master clock sources; code 3 is refused
  typedef enum logic [1:0] {
    SRC_SLOW = 2'b00,
    SRC_MAIN = 2'b01,
    SRC_PLL = 2'b10
  } source_type;

  // clock source switch sequence
  typedef enum logic [1:0] {
    SW_RUN = 2'b00,
    SW_DRAIN_OLD = 2'b01,
    SW_FILL_NEW = 2'b11
  } switch_type;

  // clock_gen_mode_reg layout
  typedef struct packed {
    logic [1:0] reserved_hi;
    logic [5:0] lock_count_field;
    logic [1:0] clock_source_select;
    logic [5:0] multiplier_field;
    logic [7:0] osc_startup_count;
    logic clock_out_disable_bit;
    logic [2:0] prescale;
    logic [1:0] reserved_lo;
    logic osc_bypass_bit;
    logic osc_enable_bit;
  } cgmr_type;

  // power_status_reg layout
  typedef struct packed {
    logic [28:0] zero;
    logic slow_event_flag;
    logic lock_flag;
    logic osc_stable_flag;
  } status_type;

endpackage

/* power_clock_generator.sv */
// clock generation and power modes: oscillator, multiplier, source switch
// assumes one 50 MHz sys_clk; external clocks appear as enable pulses
//
// Functional notes
// - backup reset held 32768 slow cycles after battery reset pin release.
// - main oscillator is disabled after reset.
// - clearing oscillator enable stops it and clears the stable flag.
// - enabling loads startup count, decremented every 8 cycles, zero sets stable.
// - bypass takes the clock straight from the crystal input pin.
// - multiplier output runs at multiplier field plus one times input.
// - multiplier field zero, or reset, disables the multiplier.
// - new multiplier value clears lock and loads lock counter per slow tick.
// - lock count n gives n+1 slow cycles before lock is set.
// - multiplier change restarts lock; output bypassed while lock is clear.
// - lock waits for both oscillator and lock counters to expire.
// - source select picks slow, main oscillator or multiplier clock.
// - leaving slow clock is refused unless oscillator is enabled and stable.
// - disabling the multiplier is refused while it is or becomes selected.
// - disabling the oscillator is refused unless slow clock is selected.
// - slow event flag set when switch onto slow clock completes.
// - prescaler divides by a power of two, 1 to 64, one after reset.
// - idle stops core clock until interrupt; peripherals keep running.
// - after reset the block runs from the slow clock.
// - power-down keeps main power off until wake edge or alarm.
// - clock-out disable bit tri-states the master clock output.
// - core clock enabled at reset, re-enabled by any enabled interrupt.
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
module power_clock_generator #(
  parameter int BACKUP_CYCLES = power_clock_pkg::BACKUP_STRETCH,
  parameter int MAIN_DIV = power_clock_pkg::MAIN_DIV_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic battery_reset_pin_n,
  input wire logic crystal_input_pin,
  input wire logic wake_pin,
  input wire logic alarm_event,
  input wire logic irq_request,
  output logic backup_reset,
  output logic master_clock_en,
  output logic core_clock_en,
  output logic peripheral_clock_en,
  output logic master_clock_out_pin,
  output logic master_clock_out_oe,
  output logic main_power_on,
  output power_clock_pkg::source_type master_source
);
  import power_clock_pkg::*;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);

  cgmr_type cgmr;
  cgmr_type wr_mode;
  status_type status;
  switch_type sw_state;
  source_type target_src;
  logic [2:0] pin_sync [0:2];
  logic [2:0] pin_level;
  logic xtal_prev;
  logic wake_prev;
  logic [10:0] slow_div;
  logic slow_tick;
  logic [15:0] backup_cnt;
  logic [2:0] osc_div;
  logic osc_tick;
  logic [7:0] osc_cnt;
  logic osc_stable;
  logic [7:0] main_div;
  logic main_tick;
  logic [7:0] pll_pending;
  logic pll_tick;
  logic [5:0] lock_cnt;
  logic lock;
  logic [1:0] sw_cnt;
  logic sel_tick;
  logic [5:0] pre_cnt;
  logic master_tick;
  logic slow_event;
  logic core_on;
  logic [1:0] power_mode;
  logic cgmr_wr;
  logic forbidden;
  logic cgmr_ok;
  logic mul_change;

  // tick of one clock source
  function automatic logic src_tick(source_type s, logic slow_t,
                                    logic main_t, logic pll_t);
    unique case (s)
      SRC_SLOW: src_tick = slow_t;
      SRC_MAIN: src_tick = main_t;
      SRC_PLL: src_tick = pll_t;
      default: src_tick = 1'b0;
    endcase
  endfunction

  // prescaler wrap value for a power of two, clamped at 64
  function automatic logic [5:0] pre_mask(logic [2:0] p);
    logic [2:0] c;
    c = (p > PRESCALE_MAX) ? PRESCALE_MAX : p;
    pre_mask = 6'((7'h01 << c) - 7'h01);
  endfunction

  // pin synchronisers: battery reset, crystal input, wake
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 3; i++) begin
      pin_sync[i] <= {pin_sync[i][1:0], 1'b0};
    end
    pin_sync[0][0] <= battery_reset_pin_n;
    pin_sync[1][0] <= crystal_input_pin;
    pin_sync[2][0] <= wake_pin;
  end

  // a change counts once the second and third stages agree
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pin_level <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (pin_sync[i][1] == pin_sync[i][2]) begin
          pin_level[i] <= pin_sync[i][2];
        end
      end
    end
  end

  // slow clock enable divider
  always_ff @(posedge sys_clk) begin
    if (srst || slow_div == 11'(SLOW_DIV - 1)) begin
      slow_div <= 11'h000;
    end else begin
      slow_div <= slow_div + 11'h001;
    end
  end
  assign slow_tick = (slow_div == 11'(SLOW_DIV - 1));

  // backup reset stretch after the battery reset pin rises
  always_ff @(posedge sys_clk) begin
    if (srst || !pin_level[0]) begin
      backup_cnt <= 16'h0000;
    end else if (slow_tick && backup_cnt != 16'(BACKUP_CYCLES)) begin
      backup_cnt <= backup_cnt + 16'h0001;
    end
  end
  assign backup_reset = !pin_level[0] || backup_cnt != 16'(BACKUP_CYCLES);

  // write filtering of forbidden source and enable combinations
  assign wr_mode = cgmr_type'(reg_wdata);
  assign cgmr_wr = reg_write && reg_addr == CLOCK_GEN_MODE_OFS;
  always_comb begin
    forbidden = 1'b0;
    if (wr_mode.clock_source_select == 2'b11) begin
      forbidden = 1'b1;
    end
    if (wr_mode.clock_source_select != SRC_SLOW &&
        (!cgmr.osc_enable_bit || !osc_stable ||
         !wr_mode.osc_enable_bit)) begin
      forbidden = 1'b1;
    end
    if (wr_mode.multiplier_field == 6'h00 &&
        (master_source == SRC_PLL || target_src == SRC_PLL ||
         wr_mode.clock_source_select == SRC_PLL)) begin
      forbidden = 1'b1;
    end
    if (!wr_mode.osc_enable_bit &&
        (master_source != SRC_SLOW || sw_state != SW_RUN)) begin
      forbidden = 1'b1;
    end
    if (sw_state != SW_RUN &&
        wr_mode.clock_source_select != cgmr.clock_source_select) begin
      forbidden = 1'b1; // one switch at a time
    end
  end
  assign cgmr_ok = cgmr_wr && !forbidden;
  assign mul_change = cgmr_ok &&
                      wr_mode.multiplier_field != cgmr.multiplier_field;

  // mode register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cgmr <= cgmr_type'(CGMR_RESET);
    end else if (cgmr_ok) begin
      cgmr <= wr_mode;
      cgmr.reserved_hi <= 2'h0;
      cgmr.reserved_lo <= 2'h0;
    end
  end

  // oscillator counter step every eight cycles
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      osc_div <= 3'h0;
    end else begin
      osc_div <= osc_div + 3'h1;
    end
  end
  assign osc_tick = (osc_div == 3'(OSC_TICK_DIV - 1));

  // oscillator start-up count and stable flag
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      osc_cnt <= 8'h00;
      osc_stable <= 1'b0;
    end else if (cgmr_ok && !wr_mode.osc_enable_bit) begin
      osc_stable <= 1'b0;
    end else if (cgmr_ok && !cgmr.osc_enable_bit) begin
      osc_cnt <= wr_mode.osc_startup_count;
      osc_stable <= 1'b0;
    end else if (cgmr.osc_enable_bit && !osc_stable && osc_tick) begin
      if (osc_cnt == 8'h00) begin
        osc_stable <= 1'b1;
      end else begin
        osc_cnt <= osc_cnt - 8'h01;
      end
    end
  end

  // main clock: internal crystal model or bypassed input pin
  always_ff @(posedge sys_clk) begin
    if (srst || main_div == 8'(MAIN_DIV - 1)) begin
      main_div <= 8'h00;
    end else begin
      main_div <= main_div + 8'h01;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      xtal_prev <= 1'b0;
    end else begin
      xtal_prev <= pin_level[1];
    end
  end
  assign main_tick = cgmr.osc_enable_bit && osc_stable &&
                     (cgmr.osc_bypass_bit ? (pin_level[1] && !xtal_prev)
                                          : main_div == 8'(MAIN_DIV - 1));

  // multiplier: mul+1 ticks per input tick, saturating backlog
  always_ff @(posedge sys_clk) begin
    if (srst || cgmr.multiplier_field == 6'h00) begin
      pll_pending <= 8'h00;
    end else begin
      pll_pending <= pll_pending
        + ((main_tick && !pll_pending[7])
           ? 8'({2'b00, cgmr.multiplier_field} + 8'h01) : 8'h00)
        - ((pll_pending != 8'h00) ? 8'h01 : 8'h00);
    end
  end
  assign pll_tick = lock ? (pll_pending != 8'h00) : main_tick;

  // lock counter and lock flag
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      lock_cnt <= 6'h00;
      lock <= 1'b0;
    end else if (mul_change) begin
      lock <= 1'b0;
      lock_cnt <= wr_mode.lock_count_field;
    end else if (cgmr.multiplier_field == 6'h00 || !osc_stable ||
                 (cgmr_ok && !wr_mode.osc_enable_bit)) begin
      lock <= 1'b0;
    end else if (!lock && slow_tick) begin
      if (lock_cnt != 6'h00) begin
        lock_cnt <= lock_cnt - 6'h01;
      end else begin
        lock <= 1'b1;
      end
    end
  end

  // glitch-free source switch: drain old clock, then fill with new one
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sw_state <= SW_RUN;
      sw_cnt <= 2'h0;
      master_source <= SRC_SLOW;
      target_src <= SRC_SLOW;
    end else begin
      unique case (sw_state)
        SW_RUN: begin
          if (cgmr_ok && wr_mode.clock_source_select != master_source) begin
            target_src <= source_type'(wr_mode.clock_source_select);
            sw_state <= SW_DRAIN_OLD;
            sw_cnt <= 2'h0;
          end
        end
        SW_DRAIN_OLD: begin
          if (src_tick(master_source, slow_tick, main_tick, pll_tick)) begin
            if (sw_cnt == 2'(SWITCH_TICKS - 1)) begin
              sw_state <= SW_FILL_NEW;
              sw_cnt <= 2'h0;
            end else begin
              sw_cnt <= sw_cnt + 2'h1;
            end
          end
        end
        SW_FILL_NEW: begin
          if (src_tick(target_src, slow_tick, main_tick, pll_tick)) begin
            if (sw_cnt == 2'(SWITCH_TICKS - 1)) begin
              sw_state <= SW_RUN;
              master_source <= target_src;
            end else begin
              sw_cnt <= sw_cnt + 2'h1;
            end
          end
        end
        default: sw_state <= SW_RUN;
      endcase
    end
  end
  assign sel_tick = (sw_state == SW_RUN) &&
                    src_tick(master_source, slow_tick, main_tick, pll_tick);

  // power-of-two prescaler
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pre_cnt <= 6'h00;
    end else if (sel_tick) begin
      pre_cnt <= (pre_cnt >= pre_mask(cgmr.prescale)) ? 6'h00
                                                      : pre_cnt + 6'h01;
    end
  end
  assign master_tick = sel_tick && pre_cnt >= pre_mask(cgmr.prescale);

  // master, core and peripheral clock enables and clock output pin
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      master_clock_en <= 1'b0;
      core_clock_en <= 1'b0;
      peripheral_clock_en <= 1'b0;
      master_clock_out_pin <= 1'b0;
      master_clock_out_oe <= 1'b0;
    end else begin
      master_clock_en <= master_tick;
      core_clock_en <= master_tick && core_on;
      peripheral_clock_en <= master_tick;
      master_clock_out_oe <= !cgmr.clock_out_disable_bit;
      if (master_tick) begin
        master_clock_out_pin <= !master_clock_out_pin;
      end
    end
  end

  // core clock: idle on disable write, woken by an enabled interrupt
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      core_on <= 1'b1;
    end else if (irq_request ||
                 (reg_write && reg_addr == SYS_CLK_ENABLE_OFS &&
                  reg_wdata[0])) begin
      core_on <= 1'b1;
    end else if (reg_write && reg_addr == SYS_CLK_DISABLE_OFS &&
                 reg_wdata[0]) begin
      core_on <= 1'b0;
    end
  end

  // slow event flag: set on completed switch to slow, cleared by read
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      slow_event <= 1'b0;
    end else if (sw_state == SW_FILL_NEW && target_src == SRC_SLOW &&
                 slow_tick && sw_cnt == 2'(SWITCH_TICKS - 1)) begin
      slow_event <= 1'b1;
    end else if (reg_read && reg_addr == POWER_STATUS_OFS) begin
      slow_event <= 1'b0;
    end
  end

  // power mode and main supply: shutdown command, wake edge or alarm
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      power_mode <= POWER_MODE_RESET;
      wake_prev <= 1'b0;
      main_power_on <= 1'b1;
    end else begin
      wake_prev <= pin_level[2];
      if (reg_write && reg_addr == POWER_MODE_OFS) begin
        power_mode <= reg_wdata[1:0];
      end
      if ((pin_level[2] != wake_prev && pin_level[2] == power_mode[0]) ||
          (alarm_event && power_mode[1])) begin
        main_power_on <= 1'b1;
      end else if (reg_write && reg_addr == POWER_CTRL_OFS &&
                   reg_wdata[0]) begin
        main_power_on <= 1'b0;
      end
    end
  end

  // read data, valid only in the cycle after the read strobe
  assign status = '{zero: 29'h0, slow_event_flag: slow_event,
                    lock_flag: lock, osc_stable_flag: osc_stable};
  always_ff @(posedge sys_clk) begin
    if (srst || !reg_read) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      unique case (reg_addr)
        SYS_CLK_STATUS_OFS: reg_rdata <= {31'h0000_0000, core_on};
        CLOCK_GEN_MODE_OFS: reg_rdata <= cgmr;
        POWER_MODE_OFS: reg_rdata <= {30'h0000_0000, power_mode};
        POWER_STATUS_OFS: reg_rdata <= status;
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // checks
  sequence pin_release;
    !pin_level[0] ##1 pin_level[0];
  endsequence
  sequence slow_switch_done;
    sw_state == SW_FILL_NEW && target_src == SRC_SLOW && slow_tick &&
    sw_cnt == 2'(SWITCH_TICKS - 1);
  endsequence

  a_backup_hold: assert property (pin_release |-> backup_reset [*8])
    else $error("backup reset released too early");
  a_osc_stop_clear: assert property (
    cgmr_ok && !wr_mode.osc_enable_bit |=> !osc_stable && !lock)
    else $error("stable flag kept after oscillator disable");
  a_lock_restart: assert property (
    mul_change |=> !lock && lock_cnt == $past(wr_mode.lock_count_field))
    else $error("lock not restarted on multiplier change");
  a_lock_after_osc: assert property (lock |-> osc_stable)
    else $error("lock set before oscillator stable");
  a_pll_bypass: assert property (!lock |-> pll_tick == main_tick)
    else $error("multiplier output not bypassed while unlocked");
  a_slow_deselect: assert property (
    cgmr_wr && wr_mode.clock_source_select != SRC_SLOW && !osc_stable
    |=> cgmr == $past(cgmr))
    else $error("source left slow clock without stable oscillator");
  a_pll_kept: assert property (
    cgmr_wr && master_source == SRC_PLL && wr_mode.multiplier_field == 6'h00
    |=> cgmr.multiplier_field != 6'h00)
    else $error("multiplier disabled while selected");
  a_osc_kept: assert property (
    cgmr_wr && master_source != SRC_SLOW && !wr_mode.osc_enable_bit
    |=> cgmr.osc_enable_bit)
    else $error("oscillator disabled off slow clock");
  a_slow_event: assert property (
    slow_switch_done |=> slow_event && master_source == SRC_SLOW)
    else $error("slow event missing after switch");
  a_prescale_one: assert property (
    sel_tick && cgmr.prescale == 3'h0 |=> master_clock_en)
    else $error("undivided master tick lost");
  a_core_wake: assert property (irq_request |=> core_on)
    else $error("interrupt did not wake core clock");

endmodule

/* board_model.sv */
// board model: battery reset rc network, free running external clock
// and a wake push-button; assumes the bench clock paces every pin
`timescale 1ns/1ns
module board_model #(
  parameter int RELEASE_CYCLES = 20,
  parameter int HALF_PERIOD = 5
) (
  input wire logic sys_clk,
  input wire logic wake_req,
  input wire logic main_power_on,
  output logic battery_reset_pin_n,
  output logic crystal_input_pin,
  output logic wake_pin
);
  int age = 0;
  int phase = 0;

  // pins start low, as after battery power-up
  initial begin
    battery_reset_pin_n = 1'b0;
    crystal_input_pin = 1'b0;
    wake_pin = 1'b0;
  end

  // rc network lets the battery reset pin rise after a while
  always @(posedge sys_clk) begin
    age <= age + 1;
    if (age >= RELEASE_CYCLES) battery_reset_pin_n <= 1'b1;
  end

  // external clock runs free; the block has to synchronise it
  always @(posedge sys_clk) begin
    phase <= (phase == HALF_PERIOD - 1) ? 0 : phase + 1;
    if (phase == HALF_PERIOD - 1) crystal_input_pin <= ~crystal_input_pin;
  end

  // button only gives an edge while the main supply is off
  always @(posedge sys_clk) wake_pin <= wake_req & ~main_power_on;
endmodule

/* tb_power_clock_generator.sv */
// self-checking bench of the power clock generator
// assumes board_model on the pins and a 50 MHz sys_clk
`timescale 1ns/1ns
module tb_power_clock_generator;
  import power_clock_pkg::*;
  localparam int BK = 4;
  localparam int MD = MAIN_DIV_DEFAULT;
  localparam int LIMIT = 60000;
  typedef struct {
    logic [31:0] wdata;
    int wait_n;
    logic [31:0] mode;
    logic [2:0] stat;
    logic [2:0] mask;
    source_type src;
  } row_type;
  logic sys_clk, srst, reg_write, reg_read, wake_req, alarm_event;
  logic irq_request, battery_reset_pin_n, crystal_input_pin, wake_pin;
  logic backup_reset, master_clock_en, core_clock_en, peripheral_clock_en;
  logic master_clock_out_pin, master_clock_out_oe, main_power_on;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic mo;
  source_type master_source;
  int cyc = 0, num_errors = 0, n_checks = 0, t, n, cc, pc, oc;
  row_type rows[13] = '{
    '{32'h0040_0000, 10, 32'h0000_0000, 3'h0, 3'h7, SRC_SLOW},
    '{32'h0080_0000, 10, 32'h0000_0000, 3'h0, 3'h7, SRC_SLOW},
    '{32'h00c0_0000, 10, 32'h0000_0000, 3'h0, 3'h7, SRC_SLOW},
    '{32'h0000_0421, 100, 32'h0000_0421, 3'h1, 3'h7, SRC_SLOW},
    '{32'h0040_0421, 3500, 32'h0040_0421, 3'h1, 3'h7, SRC_MAIN},
    '{32'h0040_0420, 10, 32'h0040_0421, 3'h1, 3'h7, SRC_MAIN},
    '{32'h0141_0421, 5000, 32'h0141_0421, 3'h3, 3'h7, SRC_MAIN},
    '{32'h0180_0421, 10, 32'h0141_0421, 3'h3, 3'h7, SRC_MAIN},
    '{32'h0181_0421, 200, 32'h0181_0421, 3'h3, 3'h7, SRC_PLL},
    '{32'h0180_0421, 10, 32'h0181_0421, 3'h3, 3'h7, SRC_PLL},
    '{32'h0001_0420, 10, 32'h0181_0421, 3'h3, 3'h7, SRC_PLL},
    '{32'h0101_0421, 4000, 32'h0101_0421, 3'h7, 3'h7, SRC_SLOW},
    '{32'h0100_0420, 20, 32'h0100_0420, 3'h0, 3'h1, SRC_SLOW}
  };

  power_clock_generator #(.BACKUP_CYCLES(BK), .MAIN_DIV(MD)) dut (
    .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .battery_reset_pin_n(battery_reset_pin_n),
    .crystal_input_pin(crystal_input_pin), .wake_pin(wake_pin),
    .alarm_event(alarm_event), .irq_request(irq_request),
    .backup_reset(backup_reset), .master_clock_en(master_clock_en),
    .core_clock_en(core_clock_en),
    .peripheral_clock_en(peripheral_clock_en),
    .master_clock_out_pin(master_clock_out_pin),
    .master_clock_out_oe(master_clock_out_oe),
    .main_power_on(main_power_on), .master_source(master_source));

  board_model #(.RELEASE_CYCLES(20), .HALF_PERIOD(5)) board (
    .sys_clk(sys_clk), .wake_req(wake_req), .main_power_on(main_power_on),
    .battery_reset_pin_n(battery_reset_pin_n),
    .crystal_input_pin(crystal_input_pin), .wake_pin(wake_pin));

  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // cycle count and hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e, string nm);
    @(posedge sys_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 chk(nm, reg_rdata, e);
  endtask

  // status read, only the flags selected by the mask are compared
  task automatic rs(input logic [2:0] m, e, input string nm);
    @(posedge sys_clk);
    reg_read <= 1'b1;
    reg_addr <= POWER_STATUS_OFS;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 chk(nm, reg_rdata & 32'(m), 32'(e));
  endtask

  // cycles between two master ticks, after skipping two
  task automatic tick_gap(output int g);
    g = 0;
    for (t = 0; t < 3000 && g < 2; t++) begin
      @(posedge sys_clk);
      #1 if (master_clock_en === 1'b1) g++;
    end
    for (g = 1; g < 3000; g++) begin
      @(posedge sys_clk);
      #1 if (master_clock_en === 1'b1) break;
    end
  endtask

  // main sequence
  initial begin
    srst = 1'b1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    wake_req = 1'b0;
    alarm_event = 1'b0;
    irq_request = 1'b0;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    #1 chk("backup_reset", backup_reset, 1);
    rc(8'h20, CGMR_RESET, "mode");
    rc(8'h08, 32'h0000_0001, "core_on");
    rc(8'h2c, 32'(POWER_MODE_RESET), "power_mode");
    rc(8'h3c, 32'h0000_0000, "unmapped");
    chk("source", 32'(master_source), 32'(SRC_SLOW));
    chk("clock_out_oe", master_clock_out_oe, 1);
    for (t = 0; t < 12000 && backup_reset !== 1'b0; t++) @(posedge sys_clk);
    n = cyc - 20;
    chk("backup_len", n >= (BK-1)*SLOW_DIV && n <= (BK+1)*SLOW_DIV, 1);
    for (int i = 0; i < 13; i++) begin
      wr(8'h20, rows[i].wdata);
      repeat (rows[i].wait_n) @(posedge sys_clk);
      rc(8'h20, rows[i].mode, "mode");
      rs(rows[i].mask, rows[i].stat, "status");
      chk("src", 32'(master_source), 32'(rows[i].src));
    end
    // lock must wait n+1 slow ticks, also with the oscillator restarting
    wr(8'h20, 32'h0101_ff01);
    repeat (SLOW_DIV - 40) @(posedge sys_clk);
    rc(8'h30, 32'h0000_0000, "status_early");
    repeat (5000) @(posedge sys_clk);
    rc(8'h30, 32'h0000_0003, "status_locked");
    // prescaler on the main clock, every division
    for (int p = 0; p < 7; p++) begin
      wr(8'h20, 32'h0141_ff01 | (32'(p) << 4));
      if (p == 0) repeat (3500) @(posedge sys_clk);
      tick_gap(n);
      chk("tick_gap", n, MD << p);
    end
    wr(8'h20, 32'h0141_ff03);
    tick_gap(n);
    chk("bypass_gap", n, 10);
    wr(8'h20, 32'h0141_ff83);
    repeat (3) @(posedge sys_clk);
    chk("clock_out_oe", master_clock_out_oe, 0);
    // idle: core stops, peripherals keep ticking, interrupt wakes
    wr(8'h04, 32'h0000_0001);
    rc(8'h08, 32'h0000_0000, "core_on");
    cc = 0;
    pc = 0;
    oc = 0;
    mo = master_clock_out_pin;
    repeat (200) begin
      @(posedge sys_clk);
      #1 cc += (core_clock_en === 1'b1);
      pc += (peripheral_clock_en === 1'b1);
      oc += (master_clock_out_pin !== mo);
      mo = master_clock_out_pin;
    end
    chk("out_toggles", oc, pc);
    chk("core_ticks", cc, 0);
    chk("periph_ticks", pc > 0, 1);
    irq_request <= 1'b1;
    rc(8'h08, 32'h0000_0001, "core_on");
    irq_request <= 1'b0;
    // power-down, then wake by pin edge and by alarm
    wr(8'h28, 32'h0000_0001);
    repeat (20) @(posedge sys_clk);
    chk("power", main_power_on, 0);
    wake_req <= 1'b1;
    for (t = 0; t < 20 && main_power_on !== 1'b1; t++) @(posedge sys_clk);
    chk("power_wake", main_power_on, 1);
    wake_req <= 1'b0;
    wr(8'h2c, 32'h0000_0003);
    wr(8'h28, 32'h0000_0001);
    repeat (5) @(posedge sys_clk);
    alarm_event <= 1'b1;
    @(posedge sys_clk);
    alarm_event <= 1'b0;
    for (t = 0; t < 20 && main_power_on !== 1'b1; t++) @(posedge sys_clk);
    chk("power_alarm", main_power_on, 1);
    // second reset in mid-run brings slow clock mode back
    srst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    rc(8'h20, CGMR_RESET, "mode");
    chk("source", 32'(master_source), 32'(SRC_SLOW));
    chk("clock_out_oe", master_clock_out_oe, 1);
    complete_run();
  end
endmodule
